// ### design/fault_report_pkg.sv
package fault_report_pkg;

    // =========================================================
    // Sizes
    // =========================================================
    localparam int EP_NUM   = 8;
    localparam int EP_IDX_W = 3;
    localparam int CNT_W    = 9;
    localparam int TAG_W    = 8;
    localparam int CAT_NUM  = 4;
    localparam int ADDR_W   = 12;

    // =========================================================
    // Categories
    // =========================================================
    localparam int CAT_EP  = 0;
    localparam int CAT_ERR = 1;
    localparam int CAT_TMO = 2;
    localparam int CAT_RST = 3;

    // =========================================================
    // Register offsets (byte addresses)
    // =========================================================
    localparam logic [11:0] EP_STAT_OFF   = 12'h900;
    localparam logic [11:0] EP_CTRL_OFF   = 12'h904;
    localparam logic [11:0] ERR_STAT_OFF  = 12'h908;
    localparam logic [11:0] ERR_CTRL_OFF  = 12'h90C;
    localparam logic [11:0] TMO_STAT_OFF  = 12'h910;
    localparam logic [11:0] TMO_CTRL_OFF  = 12'h914;
    localparam logic [11:0] RST_STAT_OFF  = 12'h918;
    localparam logic [11:0] RST_CTRL_OFF  = 12'h91C;
    localparam logic [11:0] IRQ_STAT_OFF  = 12'h980;
    localparam logic [11:0] IRQ_EN_OFF    = 12'h984;

    // =========================================================
    // Field positions and reset values
    // =========================================================
    localparam int CNT_LSB  = 16;
    localparam int DIR_BIT  = 8;
    localparam int TAG_LSB  = 0;
    localparam int MASK_BIT = 0;
    localparam logic [3:0]  MASK_RST   = 4'h0;
    localparam logic [3:0]  IRQ_EN_RST = 4'h0;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [CNT_W-1:0] count_ones(
        input logic [EP_NUM-1:0] v);
        logic [CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < EP_NUM; i++) begin
            n = n + CNT_W'(v[i]);
        end
        return n;
    endfunction

    function automatic logic [EP_IDX_W-1:0] lowest_set(
        input logic [EP_NUM-1:0] v);
        logic [EP_IDX_W-1:0] k;
        k = '0;
        for (int i = EP_NUM - 1; i >= 0; i--) begin
            if (v[i]) begin
                k = EP_IDX_W'(i);
            end
        end
        return k;
    endfunction

    function automatic logic [31:0] report_word(
        input logic [CNT_W-1:0] cnt,
        input logic             mgr,
        input logic [TAG_W-1:0] tag);
        logic [31:0] w;
        w = WORD_ZERO;
        w[CNT_LSB +: CNT_W] = cnt;
        w[DIR_BIT] = mgr;
        w[TAG_LSB +: TAG_W] = tag;
        return w;
    endfunction

endpackage

// ### design/fault_category_tracker.sv
`timescale 1ns/1ns
module fault_category_tracker (
    input  wire logic                                    i_clk_sys,
    input  wire logic                                    i_srst,
    input  wire logic                                    i_ce,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]     i_level,
    input  wire logic [fault_report_pkg::EP_NUM*8-1:0]   i_tags,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]     i_is_mgr,
    output logic      [fault_report_pkg::CNT_W-1:0]      o_count,
    output logic      [fault_report_pkg::TAG_W-1:0]      o_tag,
    output logic                                         o_mgr,
    output logic                                         o_rise
);

    logic [fault_report_pkg::CNT_W-1:0]    count_d;
    logic [fault_report_pkg::EP_IDX_W-1:0] first_idx;
    logic                                  rise;

    always_comb begin
        count_d   = fault_report_pkg::count_ones(i_level);
        first_idx = fault_report_pkg::lowest_set(i_level);
        rise      = (o_count == '0) && (count_d != '0);
    end

    // =========================================================
    // Live count of signalling interfaces
    // =========================================================
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_count <= '0;
        end else if (i_ce) begin
            o_count <= count_d; // RULE3
        end
    end

    // =========================================================
    // First offender, frozen while the count stays nonzero
    // =========================================================
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_tag <= '0;
            o_mgr <= 1'b0;
        end else if (i_ce && rise) begin
            o_tag <= i_tags[first_idx*8 +: 8]; // RULE5 RULE15
            o_mgr <= i_is_mgr[first_idx];      // RULE4
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rise <= 1'b0;
        end else if (i_ce) begin
            o_rise <= rise;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    property p_capture_first;
        @(posedge i_clk_sys) disable iff (i_srst)
        (i_ce && !i_srst && rise) |=>
            (o_tag == $past(i_tags[first_idx*8 +: 8]))
            && (o_mgr == $past(i_is_mgr[first_idx]));
    endproperty
    a_capture_first: assert property (p_capture_first) // RULE5
        else $error("first offender tag not captured");

    property p_freeze;
        @(posedge i_clk_sys) disable iff (i_srst)
        (o_count != '0) |=> ($stable(o_tag) && $stable(o_mgr));
    endproperty
    a_freeze: assert property (p_freeze) // RULE15
        else $error("first offender changed while count nonzero");

endmodule

// ### design/domain_fault_report_regs.sv
`timescale 1ns/1ns
// Operation
// RULE1 - Mask bit set to one suppresses all interrupts of its category
// RULE2 - Software writes zero to reserved bits; their read value is undefined
// RULE3 - Error report shows count of interfaces now raising errors
// RULE4 - Error report direction bit: 0 subordinate, 1 manager
// RULE5 - Error report holds tag of first interface raising an error
// RULE6 - Timeout report shows count of interfaces now raising timeouts
// RULE7 - Timeout report direction bit: 0 subordinate, 1 manager
// RULE8 - Timeout report holds tag of first interface raising a timeout
// RULE9 - Reset-activity report holds first tag, count and direction
// RULE10 - Only secure accesses may read or write these registers
// RULE11 - Error, timeout, reset registers exist only with monitored endpoints
// RULE12 - Timeout reporting is kept separate from error and reset reporting
// RULE13 - Endpoint report has same fields; mask in endpoint control
// RULE14 - Category interrupt high while count nonzero and mask clear
// RULE15 - First tag and direction frozen until count returns to zero
module domain_fault_report_regs #(
    parameter bit HAS_MONITORED_EP = 1'b1
) (
    input  wire logic                                   i_clk_sys,
    input  wire logic                                   i_srst,
    input  wire logic                                   i_ce,
    input  wire logic                                   i_psel,
    input  wire logic                                   i_penable,
    input  wire logic                                   i_pwrite,
    input  wire logic [fault_report_pkg::ADDR_W-1:0]    i_paddr,
    input  wire logic [31:0]                            i_pwdata,
    input  wire logic [3:0]                             i_pstrb,
    input  wire logic [2:0]                             i_pprot,
    output logic      [31:0]                            o_prdata,
    output logic                                        o_pready,
    output logic                                        o_pslverr,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]    i_ep_fault,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]    i_err_fault,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]    i_tmo_fault,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]    i_rst_fault,
    input  wire logic [fault_report_pkg::EP_NUM*8-1:0]  i_ep_tags,
    input  wire logic [fault_report_pkg::EP_NUM-1:0]    i_ep_is_mgr,
    output logic      [fault_report_pkg::CAT_NUM-1:0]   o_cat_irq,
    output logic                                        o_irq
);

    localparam int NC = fault_report_pkg::CAT_NUM;
    localparam int CW = fault_report_pkg::CNT_W;
    localparam int TW = fault_report_pkg::TAG_W;

    logic [fault_report_pkg::EP_NUM-1:0] lvl [NC];
    logic [CW-1:0]   cnt [NC];
    logic [TW-1:0]   tag [NC];
    logic [NC-1:0]   mgr;
    logic [NC-1:0]   rise;
    logic [NC-1:0]   mask_q;
    logic [NC-1:0]   irq_sts_q;
    logic [NC-1:0]   irq_sts_d;
    logic [NC-1:0]   irq_en_q;
    logic [NC-1:0]   clr_bits;
    logic            acc;
    logic            first_cyc;
    logic            fire_wr;
    logic            hit;
    logic            bad;
    logic [31:0]     rd_word;

    // =========================================================
    // Event sources; monitored categories vanish when absent
    // =========================================================
    always_comb begin
        lvl[fault_report_pkg::CAT_EP]  = i_ep_fault; // RULE13
        lvl[fault_report_pkg::CAT_ERR] =
            i_err_fault & {fault_report_pkg::EP_NUM{HAS_MONITORED_EP}};
        lvl[fault_report_pkg::CAT_TMO] =
            i_tmo_fault & {fault_report_pkg::EP_NUM{HAS_MONITORED_EP}};
        lvl[fault_report_pkg::CAT_RST] =
            i_rst_fault & {fault_report_pkg::EP_NUM{HAS_MONITORED_EP}};
    end

    // One independent tracker per category
    for (genvar c = 0; c < NC; c++) begin : g_cat
        fault_category_tracker u_trk (
            .i_clk_sys (i_clk_sys),
            .i_srst    (i_srst),
            .i_ce      (i_ce),
            .i_level   (lvl[c]),
            .i_tags    (i_ep_tags),
            .i_is_mgr  (i_ep_is_mgr),
            .o_count   (cnt[c]),
            .o_tag     (tag[c]),
            .o_mgr     (mgr[c]),
            .o_rise    (rise[c])
        ); // RULE12
    end

    // =========================================================
    // APB decode
    // =========================================================
    assign acc       = i_psel && i_penable;
    assign first_cyc = acc && !o_pready;
    assign fire_wr   = acc && o_pready && i_pwrite && !o_pslverr;

    always_comb begin
        hit     = 1'b1;
        rd_word = fault_report_pkg::WORD_ZERO;
        unique case (i_paddr)
            fault_report_pkg::EP_STAT_OFF:
                rd_word = fault_report_pkg::report_word(
                    cnt[0], mgr[0], tag[0]); // RULE13
            fault_report_pkg::EP_CTRL_OFF:
                rd_word[fault_report_pkg::MASK_BIT] = mask_q[0];
            fault_report_pkg::ERR_STAT_OFF:
                rd_word = fault_report_pkg::report_word(
                    cnt[1], mgr[1], tag[1]); // RULE3 RULE4 RULE5
            fault_report_pkg::ERR_CTRL_OFF:
                rd_word[fault_report_pkg::MASK_BIT] = mask_q[1];
            fault_report_pkg::TMO_STAT_OFF:
                rd_word = fault_report_pkg::report_word(
                    cnt[2], mgr[2], tag[2]); // RULE6 RULE7 RULE8
            fault_report_pkg::TMO_CTRL_OFF:
                rd_word[fault_report_pkg::MASK_BIT] = mask_q[2];
            fault_report_pkg::RST_STAT_OFF:
                rd_word = fault_report_pkg::report_word(
                    cnt[3], mgr[3], tag[3]); // RULE9
            fault_report_pkg::RST_CTRL_OFF:
                rd_word[fault_report_pkg::MASK_BIT] = mask_q[3];
            fault_report_pkg::IRQ_STAT_OFF:
                rd_word[NC-1:0] = irq_sts_q;
            fault_report_pkg::IRQ_EN_OFF:
                rd_word[NC-1:0] = irq_en_q;
            default:
                hit = 1'b0;
        endcase
        if (!HAS_MONITORED_EP && i_paddr >= fault_report_pkg::ERR_STAT_OFF
            && i_paddr <= fault_report_pkg::RST_CTRL_OFF) begin
            hit = 1'b0; // RULE11
        end
        bad = !hit || i_pprot[1]; // RULE10
        if (bad) begin
            rd_word = fault_report_pkg::WORD_ZERO;
        end
    end

    // =========================================================
    // APB answer: one wait state, all outputs registered
    // =========================================================
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= fault_report_pkg::WORD_ZERO;
        end else if (i_ce) begin
            o_pready <= first_cyc;
            if (first_cyc) begin
                o_pslverr <= bad;
                o_prdata  <= i_pwrite ? fault_report_pkg::WORD_ZERO : rd_word;
            end else begin
                o_pslverr <= 1'b0;
                o_prdata  <= fault_report_pkg::WORD_ZERO;
            end
        end
    end

    // =========================================================
    // Category mask and interrupt enable registers
    // =========================================================
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            mask_q   <= fault_report_pkg::MASK_RST;
            irq_en_q <= fault_report_pkg::IRQ_EN_RST;
        end else if (i_ce && fire_wr && i_pstrb[0]) begin
            unique case (i_paddr)
                fault_report_pkg::EP_CTRL_OFF:
                    mask_q[0] <= i_pwdata[fault_report_pkg::MASK_BIT];
                fault_report_pkg::ERR_CTRL_OFF:
                    mask_q[1] <= i_pwdata[fault_report_pkg::MASK_BIT];
                fault_report_pkg::TMO_CTRL_OFF:
                    mask_q[2] <= i_pwdata[fault_report_pkg::MASK_BIT];
                fault_report_pkg::RST_CTRL_OFF:
                    mask_q[3] <= i_pwdata[fault_report_pkg::MASK_BIT];
                fault_report_pkg::IRQ_EN_OFF:
                    irq_en_q  <= i_pwdata[NC-1:0];
                default: ;
            endcase
        end
    end

    // =========================================================
    // Sticky interrupt status, write one to clear, set wins
    // =========================================================
    always_comb begin
        clr_bits = '0;
        if (fire_wr && i_pstrb[0]
            && i_paddr == fault_report_pkg::IRQ_STAT_OFF) begin
            clr_bits = i_pwdata[NC-1:0];
        end
        irq_sts_d = (irq_sts_q & ~clr_bits) | rise;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_sts_q <= '0;
            o_irq     <= 1'b0;
            o_cat_irq <= '0;
        end else if (i_ce) begin
            irq_sts_q <= irq_sts_d;
            o_irq     <= |(irq_sts_q & irq_en_q & ~mask_q); // RULE1
            for (int c = 0; c < NC; c++) begin
                o_cat_irq[c] <= (cnt[c] != '0) && !mask_q[c]; // RULE14
            end
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    property p_mask_blocks;
        (i_ce && mask_q[1]) |=> !o_cat_irq[1];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) // RULE1
        else $error("masked category raised its interrupt");

    property p_cat_irq_on;
        (i_ce && !mask_q[2] && cnt[2] != '0) |=> o_cat_irq[2];
    endproperty
    a_cat_irq_on: assert property (p_cat_irq_on) // RULE14
        else $error("unmasked active category left interrupt low");

    property p_err_count;
        (i_ce && !i_srst) |=>
            cnt[1] == $past(fault_report_pkg::count_ones(lvl[1]));
    endproperty
    a_err_count: assert property (p_err_count) // RULE3
        else $error("error count differs from active interfaces");

    property p_tmo_count;
        (i_ce && !i_srst) |=>
            cnt[2] == $past(fault_report_pkg::count_ones(lvl[2]));
    endproperty
    a_tmo_count: assert property (p_tmo_count) // RULE6
        else $error("timeout count differs from active interfaces");

    property p_rst_count;
        (i_ce && !i_srst) |=>
            cnt[3] == $past(fault_report_pkg::count_ones(lvl[3]));
    endproperty
    a_rst_count: assert property (p_rst_count) // RULE9
        else $error("reset-activity count differs from active interfaces");

    property p_ep_count;
        (i_ce && !i_srst) |=>
            cnt[0] == $past(fault_report_pkg::count_ones(lvl[0]));
    endproperty
    a_ep_count: assert property (p_ep_count) // RULE13
        else $error("endpoint count differs from active interfaces");

    property p_clear_sticky;
        (i_ce && !i_srst && fire_wr && i_pstrb[0] && !rise[1]
         && i_paddr == fault_report_pkg::IRQ_STAT_OFF && i_pwdata[1])
            |=> !irq_sts_q[1];
    endproperty
    a_clear_sticky: assert property (p_clear_sticky)
        else $error("sticky status bit not cleared by write of one");

    property p_nonsecure;
        (i_ce && first_cyc && i_pprot[1]) |=>
            (o_pready && o_pslverr && o_prdata == 32'h0000_0000);
    endproperty
    a_nonsecure: assert property (p_nonsecure) // RULE10
        else $error("non-secure access not refused");

    property p_nonsecure_nowrite;
        (acc && o_pready && i_pprot[1]) |=> $stable(mask_q);
    endproperty
    a_nonsecure_nowrite: assert property (p_nonsecure_nowrite) // RULE10
        else $error("non-secure write changed a mask");

    property p_absent;
        (i_ce && first_cyc && !HAS_MONITORED_EP
         && i_paddr == fault_report_pkg::ERR_STAT_OFF) |=> o_pslverr;
    endproperty
    a_absent: assert property (p_absent) // RULE11
        else $error("absent register answered without error");

    property p_tmo_separate;
        (i_ce && rise[2] && !rise[1] && !irq_sts_q[1] && !clr_bits[1])
            |=> (irq_sts_q[2] && !irq_sts_q[1]);
    endproperty
    a_tmo_separate: assert property (p_tmo_separate) // RULE12
        else $error("timeout event not kept separate");

    property p_set_wins;
        (i_ce && rise[0]) |=> irq_sts_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) // RULE13
        else $error("endpoint event lost");

    property p_ready_one;
        (i_ce && first_cyc) |=> o_pready ##1 !o_pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready not a single cycle pulse");

    c_err_rise: cover property (i_ce && rise[1]);
    c_secure_read: cover property (acc && o_pready && !i_pwrite && !o_pslverr);
    c_irq_clear: cover property (o_irq ##1 !o_irq);
    c_refused: cover property (acc && o_pready && o_pslverr);
    c_cat_irq: cover property (o_cat_irq[1] ##1 !o_cat_irq[1]);

endmodule

// ### bench/test_domain_fault_report_regs.sv
`timescale 1ns/1ns
module test_domain_fault_report_regs;
    // =========================================================
    // Signals
    // =========================================================
    logic        clk_sys;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [2:0]  pprot;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pslverr_bare;
    logic        ce;
    logic [3:0]  pstrb;
    logic [7:0]  flt [4];
    logic [63:0] tags;
    logic [7:0]  mgr;
    logic [3:0]  cat_irq;
    logic        irq;
    int          err_total;
    int          checked;
    int          cycles;
    int          seed;
    int          m_cnt [4];
    logic [7:0]  m_tag [4];
    logic        m_dir [4];
    logic [3:0]  sticky_m;
    logic [3:0]  mask_m;
    logic [3:0]  en_m;
    logic [31:0] r;
    logic        e;
    logic        e2;
    logic [7:0]  v;

    // =========================================================
    // Design instances
    // =========================================================
    domain_fault_report_regs #(.HAS_MONITORED_EP(1'b1))
        domain_fault_report_regs_inst (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_pprot(pprot), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_ep_fault(flt[0]), .i_err_fault(flt[1]),
        .i_tmo_fault(flt[2]), .i_rst_fault(flt[3]), .i_ep_tags(tags),
        .i_ep_is_mgr(mgr), .o_cat_irq(cat_irq), .o_irq(irq));

    // Same bus, without monitored endpoints
    domain_fault_report_regs #(.HAS_MONITORED_EP(1'b0))
        bare_domain_fault_report_regs_inst (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_pprot(pprot), .o_prdata(), .o_pready(),
        .o_pslverr(pslverr_bare), .i_ep_fault(flt[0]),
        .i_err_fault(flt[1]), .i_tmo_fault(flt[2]), .i_rst_fault(flt[3]),
        .i_ep_tags(tags), .i_ep_is_mgr(mgr), .o_cat_irq(), .o_irq());

    // =========================================================
    // Clock and timeout
    // =========================================================
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles >= 5000) begin
            err_total++;
            results();
        end
    end

    // =========================================================
    // Tasks
    // =========================================================
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [2:0] pr);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pprot   <= pr;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r  = prdata;
        e  = pslverr;
        e2 = pslverr_bare;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 3'b000);
        chk(32'(e), 32'h0000_0000);
    endtask

    task automatic rreg(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000, 3'b000);
        chk(32'(e), 32'h0000_0000);
    endtask

    function automatic logic [31:0] word(int c);
        return {7'h00, 9'(m_cnt[c]), 7'h00, m_dir[c], m_tag[c]};
    endfunction

    // Drive one category's levels and update the reference model
    task automatic set_flt(input int c, input logic [7:0] lv);
        int k;
        k = 0;
        for (int i = 7; i >= 0; i--) begin
            if (lv[i]) k = i;
        end
        flt[c] <= lv;
        if (m_cnt[c] == 0 && lv != 8'h00) begin
            m_tag[c] = tags[8*k +: 8];
            m_dir[c] = mgr[k];
            sticky_m[c] = 1'b1;
        end
        m_cnt[c] = $countones(lv);
        repeat (4) @(posedge clk_sys);
    endtask

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        seed = 82;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pprot = 3'b000;
        ce = 1'b1;
        pstrb = 4'hF;
        tags = 64'h0000_0000_0000_0000;
        mgr = 8'h00;
        cycles = 0;
        err_total = 0;
        checked = 0;
        sticky_m = 4'h0;
        mask_m = 4'h0;
        en_m = 4'hF;
        for (int c = 0; c < 4; c++) begin
            flt[c] = 8'h00;
            m_cnt[c] = 0;
            m_tag[c] = 8'h00;
            m_dir[c] = 1'b0;
        end
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            rreg(12'h900 + 12'(8 * c));
            chk(r, word(c));
            rreg(12'h904 + 12'(8 * c));
            chk(r, 32'h0000_0000);
        end
        wreg(12'h984, 32'h0000_000F);
        for (int c = 0; c < 4; c++) begin
            tags <= {$random(seed), $random(seed)};
            mgr  <= 8'($random(seed));
            v = 8'($random(seed));
            @(posedge clk_sys);
            set_flt(c, v | 8'h10);
            rreg(12'h900 + 12'(8 * c));
            chk(r, word(c));
            chk(32'(cat_irq), 32'(4'h1 << c));
            tags <= {$random(seed), $random(seed)};
            mgr  <= ~mgr;
            v = 8'($random(seed));
            @(posedge clk_sys);
            set_flt(c, v | 8'h01);
            rreg(12'h900 + 12'(8 * c));
            chk(r, word(c));
            wreg(12'h904 + 12'(8 * c), 32'h0000_0001);
            mask_m[c] = 1'b1;
            repeat (3) @(posedge clk_sys);
            chk(32'(cat_irq), 32'h0000_0000);
            chk(32'(irq), 32'(|(sticky_m & en_m & ~mask_m)));
            rreg(12'h904 + 12'(8 * c));
            chk(r, 32'h0000_0001);
            set_flt(c, 8'h00);
            rreg(12'h900 + 12'(8 * c));
            chk(32'(r[24:16]), 32'h0000_0000);
            wreg(12'h904 + 12'(8 * c), 32'h0000_0000);
            mask_m[c] = 1'b0;
        end
        // Sticky status, enable and write-one-to-clear
        repeat (3) @(posedge clk_sys);
        chk(32'(irq), 32'(|(sticky_m & en_m & ~mask_m)));
        rreg(12'h980);
        chk(r, 32'(sticky_m));
        wreg(12'h980, 32'h0000_0005);
        sticky_m = sticky_m & 4'hA;
        rreg(12'h980);
        chk(r, 32'(sticky_m));
        wreg(12'h984, 32'h0000_0000);
        en_m = 4'h0;
        repeat (3) @(posedge clk_sys);
        chk(32'(irq), 32'h0000_0000);
        wreg(12'h980, 32'h0000_000A);
        rreg(12'h980);
        chk(r, 32'h0000_0000);
        // Clock enable low freezes the trackers
        ce <= 1'b0;
        set_flt(1, 8'h02);
        chk(32'(cat_irq), 32'h0000_0000);
        ce <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'(cat_irq), 32'h0000_0002);
        rreg(12'h908);
        chk(r, word(1));
        // Reset in mid-run clears masks and enables
        wreg(12'h90C, 32'h0000_0001);
        wreg(12'h984, 32'h0000_000F);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rreg(12'h984);
        chk(r, 32'h0000_0000);
        // Refused accesses; a write without byte strobe 0 is ignored
        pstrb <= 4'hE;
        wreg(12'h90C, 32'h0000_0001);
        pstrb <= 4'hF;
        apb(1'b1, 12'h90C, 32'h0000_0001, 3'b010);
        chk(32'(e), 32'h0000_0001);
        chk(r, 32'h0000_0000);
        rreg(12'h90C);
        chk(r, 32'h0000_0000);
        apb(1'b0, 12'h9F0, 32'h0000_0000, 3'b000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b0, 12'h910, 32'h0000_0000, 3'b000);
        chk(32'(e2), 32'h0000_0001);
        chk(32'(e), 32'h0000_0000);
        apb(1'b0, 12'h900, 32'h0000_0000, 3'b000);
        chk(32'(e2), 32'h0000_0000);
        results();
    end
endmodule
